// ---- hw/tsca_core.sv ----
// temperature sensor: two-wire slave, registers, conversion and alert
// Function
// - normal mode starts a conversion every 100 ms period
// - analog section on for 60 ms per conversion, off for 40 ms
// - serial logic never powers down; result register keeps latest value
// - shutdown bit stops oscillator and conversions; writing 0 leaves it
// - leaving shutdown restarts oscillator in 1.7 ms, then converts
// - result stays readable while shut down
// - any addressed transaction in normal mode restarts the conversion
// - access during conversion halts it; old result returned; restarts at stop
// - result compared with both limits drives the alert pin
// - result is 12-bit twos complement in bits 15..4, low nibble zero
// - limit registers use the same left-justified format
// - one-shot bit puts the device into shutdown at once
// - pointer write 0x04 in one-shot mode runs a single conversion
// - reading pointer 0x04 returns the result register value
// - one-shot result above limit activates alert in either mode
// - interrupt mode: any register read clears the alert
// - comparator mode: one-shot below hysteresis releases the alert
// - fault count from bits 4..3 must occur consecutively
// - config 8 bits, others 16; result read-only; pointer resets to 0
// - the whole pointer byte chooses the register for later data bytes
// - 16-bit reads send the high byte first
// - bit 1 picks comparator (0) or interrupt (1) mode
module tsca_core
    import tsca_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h20,
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    // system
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // two-wire link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // converter
    input wire logic [11:0] adc_code,
    output logic analog_on,
    output logic osc_run,
    // alert pin
    output logic alert_out,
    output logic alert_oe
);
    if (CONV_CYCLES < 1 || WAKE_CYCLES < 1 || CONV_CYCLES >= PERIOD_CYCLES
        || PERIOD_CYCLES >= 2 ** TMR_W) begin : g_chk
        $error("tsca_core: timing parameters out of range");
    end

    localparam logic [TMR_W-1:0] PER_LAST = TMR_W'(PERIOD_CYCLES - 1);
    localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_CYCLES - 1);
    localparam logic [TMR_W-1:0] WAKE_LAST = TMR_W'(WAKE_CYCLES - 1);

    function automatic logic [2:0] fq_need(input logic [1:0] sel);
        case (sel)
            2'h0: fq_need = 3'h1;
            2'h1: fq_need = 3'h2;
            2'h2: fq_need = 3'h4;
            default: fq_need = 3'h6;
        endcase
    endfunction

    // ---------------- link domain (scl) ----------------
    logic link_rst_n;
    tsca_lstate_t lst;
    logic [3:0] bcnt;
    logic [7:0] shreg;
    logic rd_active, rd_second, ack_due, ev_tgl;
    tsca_ev_t ev;
    logic [15:0] tx_word;

    wire [7:0] rx_byte = {shreg[6:0], sda_in};
    wire byte_end = (bcnt == 4'h7);
    wire ack_clk = (bcnt == 4'h8);
    wire addr_hit = (rx_byte[7:1] == DEV_ADDR);
    wire [7:0] tx_byte = rd_second ? tx_word[7:0] : tx_word[15:8];
    wire drive_now = ack_due
        | (lst == L_RD && !bcnt[3] && !tx_byte[~bcnt[2:0]]);

    always_ff @(posedge scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lst <= L_ADDR;
            bcnt <= 4'h0;
            shreg <= 8'h00;
            rd_active <= 1'b0;
            rd_second <= 1'b0;
            ack_due <= 1'b0;
        end else begin
            bcnt <= ack_clk ? 4'h0 : bcnt + 4'h1;
            shreg <= rx_byte;
            if (ack_clk) begin
                ack_due <= 1'b0;
            end
            // the address ack clock is not a data byte: keep the high byte
            if (ack_clk && lst == L_RD && !ack_due) begin
                rd_second <= 1'b1;
                // master nack ends the read
                if (sda_in) begin
                    lst <= L_SKIP;
                end
            end
            if (byte_end) begin
                case (lst)
                    L_ADDR: begin
                        ack_due <= addr_hit;
                        rd_active <= addr_hit & rx_byte[0];
                        if (!addr_hit) begin
                            lst <= L_SKIP;
                        end else if (rx_byte[0]) begin
                            lst <= L_RD;
                        end else begin
                            lst <= L_PTR;
                        end
                    end
                    L_PTR: begin
                        ack_due <= 1'b1;
                        lst <= L_WR;
                    end
                    L_WR: begin
                        ack_due <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // event word stays put for a whole byte, far longer than the sync
    always_ff @(posedge scl or negedge nrst) begin
        if (!nrst) begin
            ev_tgl <= 1'b0;
            ev <= '0;
        end else if (byte_end && link_rst_n) begin
            if ((lst == L_ADDR && addr_hit) || lst == L_PTR
                || lst == L_WR) begin
                ev_tgl <= ~ev_tgl;
                ev.data <= rx_byte;
                ev.kind <= (lst == L_ADDR) ? EV_ADDR
                    : (lst == L_PTR) ? EV_PTR : EV_DATA;
                ev.second <= (lst == L_WR) && (bcnt == 4'h7)
                    && ev.kind == EV_DATA;
            end
        end
    end

    // sda only changes while scl is low
    always_ff @(negedge scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= drive_now;
        end
    end
    assign sda_out = 1'b0;

    // ---------------- system domain (clock) ----------------
    logic [2:0] scl_s, sda_s, ev_s;
    logic [1:0] rda_s;
    logic in_frame, touched, shot_run, hot, alert_int;
    logic [7:0] ptr, cfg, wr_msb;
    logic [15:0] temp, hyst, over;
    logic [2:0] fq_cnt;
    logic [TMR_W-1:0] tmr;
    tsca_cstate_t cst;

    wire start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    wire stop = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    wire ev_new = ev_s[2] ^ ev_s[1];
    wire ev_rd = ev_new && ev.kind == EV_ADDR && ev.data[0];
    wire ev_ptr = ev_new && ev.kind == EV_PTR;
    wire ev_dat = ev_new && ev.kind == EV_DATA;
    wire mode_off = cfg[CFG_SHUT] | cfg[CFG_SHOT];
    wire shot_go = ev_ptr && ev.data == PTR_SHOT
        && cfg[CFG_SHOT] && !cfg[CFG_SHUT];
    // addressed traffic restarts conversion at stop
    wire restart = stop & touched & ~mode_off;
    wire conv_done = cst == C_CONV && !touched && tmr == CONV_LAST;
    wire [15:0] new_temp = {adc_code, TEMP_LSB'(0)};
    wire above = $signed(new_temp) > $signed(over);
    wire below = $signed(new_temp) < $signed(hyst);
    // direction depends on present alert state
    wire flip_cond = hot ? below : above;
    wire [2:0] fq_next = flip_cond ? fq_cnt + 3'h1 : 3'h0;
    // consecutive faults reach the needed count
    wire qual = flip_cond && fq_next >= fq_need(cfg[CFG_FQ+:2]);
    // pointers 0 and 4 both show the result
    wire [15:0] sel_word =
        (ptr == PTR_TEMP || ptr == PTR_SHOT) ? temp
        : (ptr == PTR_CFG) ? {cfg, cfg}
        : (ptr == PTR_HYST) ? hyst
        : (ptr == PTR_OVER) ? over : 16'h0000;
    wire alert_act = cfg[CFG_INT] ? alert_int : hot;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            ev_s <= 3'h0;
            rda_s <= 2'h0;
        end else if (clk_en) begin
            scl_s <= {scl_s[1:0], scl};
            sda_s <= {sda_s[1:0], sda_in};
            ev_s <= {ev_s[1:0], ev_tgl};
            rda_s <= {rda_s[0], rd_active};
        end
    end

    // link reset pulses on every start so a repeated start realigns bits
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            in_frame <= 1'b0;
            link_rst_n <= 1'b0;
            touched <= 1'b0;
        end else if (clk_en) begin
            in_frame <= start | (in_frame & ~stop);
            link_rst_n <= (start | (in_frame & ~stop)) & ~start;
            touched <= (ev_new && ev.kind == EV_ADDR) | (touched & ~stop);
        end
    end

    // register file
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ptr <= PTR_RST;
            cfg <= CFG_RST;
            hyst <= HYST_RST;
            over <= OVER_RST;
            wr_msb <= 8'h00;
            tx_word <= TEMP_RST;
        end else if (clk_en) begin
            if (ev_ptr) begin
                ptr <= ev.data;
            end
            // result is read-only, config single byte
            if (ev_dat && !ev.second) begin
                wr_msb <= ev.data;
                if (ptr == PTR_CFG) begin
                    cfg <= ev.data;
                end
            end
            // limits keep the low nibble zero
            if (ev_dat && ev.second && ptr == PTR_HYST) begin
                hyst <= {wr_msb, ev.data[7:4], 4'h0};
            end
            if (ev_dat && ev.second && ptr == PTR_OVER) begin
                over <= {wr_msb, ev.data[7:4], 4'h0};
            end
            // frozen while a read shifts it out; scl never samples it moving
            if (!rda_s[1]) begin
                tx_word <= sel_word;
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cst <= C_CONV;
            tmr <= '0;
            shot_run <= 1'b0;
        end else if (clk_en) begin
            shot_run <= shot_go
                | (shot_run & ~conv_done & ~cfg[CFG_SHUT]);
            case (cst)
                C_OFF: begin
                    if (shot_go) begin
                        cst <= C_CONV;
                        tmr <= '0;
                    end else if (!mode_off) begin
                        cst <= C_WAKE;
                        tmr <= '0;
                    end
                end
                C_WAKE: begin
                    if (mode_off) begin
                        cst <= C_OFF;
                    end else if (tmr == WAKE_LAST) begin
                        cst <= C_CONV;
                        tmr <= '0;
                    end else begin
                        tmr <= tmr + 1'b1;
                    end
                end
                C_CONV: begin
                    // one-shot or shutdown stops at once
                    if (mode_off && !shot_run && !shot_go) begin
                        cst <= C_OFF;
                    end else if (restart) begin
                        tmr <= '0;
                    end else if (!touched) begin
                        tmr <= tmr + 1'b1;
                        if (conv_done) begin
                            cst <= shot_run ? C_OFF : C_IDLE;
                        end
                    end
                end
                C_IDLE: begin
                    if (mode_off && !shot_go) begin
                        cst <= C_OFF;
                    end else if (shot_go) begin
                        cst <= C_CONV;
                        tmr <= '0;
                    end else if (restart || tmr == PER_LAST) begin
                        cst <= C_CONV;
                        tmr <= '0;
                    end else begin
                        tmr <= tmr + 1'b1;
                    end
                end
                default: begin
                    cst <= C_OFF;
                end
            endcase
        end
    end
    assign osc_run = (cst != C_OFF);
    assign analog_on = (cst == C_CONV);

    // result and alert
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            temp <= TEMP_RST;
            hot <= 1'b0;
            alert_int <= 1'b0;
            fq_cnt <= 3'h0;
            alert_oe <= 1'b0;
        end else if (clk_en) begin
            // result only replaced by a finished conversion
            if (conv_done) begin
                temp <= new_temp;
                fq_cnt <= qual ? 3'h0 : fq_next;
                if (qual) begin
                    hot <= ~hot;
                end
            end
            // read clears, a new event wins
            alert_int <= (conv_done & qual) | (alert_int & ~ev_rd);
            // mode select, polarity applied at the pin
            alert_oe <= alert_act ^ cfg[CFG_POL];
        end
    end
    assign alert_out = 1'b0;

    // ---------------- checks ----------------
    AST_PERIOD: assert property (@(posedge clock) disable iff (!nrst)
        cst == C_IDLE && tmr == PER_LAST && !mode_off && !shot_go
        && clk_en |=> cst == C_CONV && tmr == 0)
        else $error("period timer did not start a conversion");

    AST_ANALOG_OFF: assert property (@(posedge clock) disable iff (!nrst)
        conv_done && !shot_run && !mode_off && clk_en
        |=> cst == C_IDLE && !analog_on && tmr == TMR_W'(CONV_CYCLES))
        else $error("analog section not off after conversion");

    AST_SHUT_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        cst == C_OFF && cfg[CFG_SHUT] |=> $stable(temp))
        else $error("result changed in shutdown");

    AST_WAKE: assert property (@(posedge clock) disable iff (!nrst)
        cst == C_WAKE && tmr == WAKE_LAST && !mode_off && clk_en
        |=> cst == C_CONV && tmr == 0)
        else $error("wake delay did not end in a conversion");

    AST_RESTART: assert property (@(posedge clock) disable iff (!nrst)
        restart && clk_en && (cst == C_CONV || cst == C_IDLE)
        |=> cst == C_CONV && tmr == 0)
        else $error("transaction did not restart conversion");

    AST_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        cst == C_CONV && touched && !restart && !mode_off
        |=> $stable(tmr) && $stable(temp))
        else $error("conversion ran during an access");

    AST_FORMAT: assert property (@(posedge clock) disable iff (!nrst)
        temp[3:0] == 4'h0 && hyst[3:0] == 4'h0 && over[3:0] == 4'h0)
        else $error("low nibble of a temperature word not zero");

    AST_SHOT_ENTER: assert property (@(posedge clock) disable iff (!nrst)
        cfg[CFG_SHOT] && !shot_run && !shot_go && cst != C_OFF && clk_en
        |=> cst == C_OFF)
        else $error("one-shot mode did not shut down");

    AST_SHOT_GO: assert property (@(posedge clock) disable iff (!nrst)
        shot_go && clk_en |=> cst == C_CONV && shot_run)
        else $error("one-shot pointer did not start a conversion");

    AST_SHOT_READ: assert property (@(posedge clock) disable iff (!nrst)
        ptr == PTR_SHOT && !rda_s[1] && clk_en |=> tx_word == $past(temp))
        else $error("one-shot read differs from result");

    AST_RD_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
        ev_rd && !(conv_done && qual) && clk_en |=> !alert_int)
        else $error("read did not clear interrupt alert");

    AST_FAULTS: assert property (@(posedge clock) disable iff (!nrst)
        conv_done && flip_cond && clk_en
        && fq_cnt + 3'h1 < fq_need(cfg[CFG_FQ+:2]) |=> $stable(hot))
        else $error("alert changed before fault count reached");

    AST_CMP_PIN: assert property (@(posedge clock) disable iff (!nrst)
        !cfg[CFG_INT] && clk_en ##1 clk_en
        |-> alert_oe == ($past(hot) ^ $past(cfg[CFG_POL])))
        else $error("comparator pin does not follow alert state");
endmodule

// ---- hw/tsca_pkg.sv ----
// package: constants and types of the temperature sensor block
package tsca_pkg;
    // register pointers
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam logic [7:0] PTR_HYST = 8'h02;
    localparam logic [7:0] PTR_OVER = 8'h03;
    localparam logic [7:0] PTR_SHOT = 8'h04;
    localparam logic [7:0] PTR_RST = 8'h00;
    // reset values
    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] HYST_RST = 16'h4b00;
    localparam logic [15:0] OVER_RST = 16'h5000;
    // configuration bit positions
    localparam int CFG_SHUT = 0;
    localparam int CFG_INT = 1;
    localparam int CFG_POL = 2;
    localparam int CFG_FQ = 3;
    localparam int CFG_SHOT = 5;
    // result field: code sits above this many zero bits
    localparam int TEMP_LSB = 4;
    // timing, times in microseconds
    localparam int CLK_MHZ = 100;
    localparam int PERIOD_US = 100000;
    localparam int CONV_US = 60000;
    localparam int WAKE_US = 1700;
    localparam int PERIOD_CYC = PERIOD_US * CLK_MHZ;
    localparam int CONV_CYC = CONV_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int TMR_W = 24;
    // link events handed to the register side
    typedef enum logic [1:0] {EV_ADDR, EV_PTR, EV_DATA} tsca_ev_kind_t;
    typedef struct packed {
        tsca_ev_kind_t kind;
        logic second;
        logic [7:0] data;
    } tsca_ev_t;
    typedef enum {L_ADDR, L_PTR, L_WR, L_RD, L_SKIP} tsca_lstate_t;
    typedef enum {C_OFF, C_WAKE, C_CONV, C_IDLE} tsca_cstate_t;
endpackage

// ---- verification/tsca_host.sv ----
// two-wire host model that reaches the sensor registers
module tsca_host
    import tsca_pkg::*;
#(
    parameter logic [6:0] ADDR = 7'h20
) (
    // link clock and wire levels
    input wire logic lclk,
    input wire logic sda,
    // driven lines
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // scl stands high between frames; sda is released to its pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // two link ticks a phase, since one tick is too short for the sync
    task automatic bit_io(input logic b, output logic r);
        @(posedge lclk) sda_low <= ~b;
        @(posedge lclk) scl <= 1'b1;
        @(posedge lclk) r = sda;
        @(posedge lclk) scl <= 1'b0;
    endtask

    task automatic start();
        @(posedge lclk) sda_low <= 1'b0;
        @(posedge lclk) scl <= 1'b1;
        repeat (2) @(posedge lclk);
        sda_low <= 1'b1;
        repeat (2) @(posedge lclk);
        scl <= 1'b0;
    endtask

    task automatic stop();
        @(posedge lclk) sda_low <= 1'b1;
        @(posedge lclk) scl <= 1'b1;
        repeat (2) @(posedge lclk);
        sda_low <= 1'b0;
        repeat (2) @(posedge lclk);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic last,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(last, ack);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [15:0] d,
                      input int n);
        logic [7:0] rx;
        logic a;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, rx, a);
        byte_io(ptr, 1'b1, rx, a);
        if (n > 0) begin
            byte_io(d[15:8], 1'b1, rx, a);
        end
        if (n > 1) begin
            byte_io(d[7:0], 1'b1, rx, a);
        end
        stop();
    endtask

    task automatic rd(input logic [7:0] ptr, input int n,
                      output logic [15:0] d);
        logic [7:0] rx;
        logic a;
        wr(ptr, 16'h0000, 0);
        start();
        byte_io({ADDR, 1'b1}, 1'b1, rx, a);
        // one byte read ends with a nack
        byte_io(8'hff, n == 1, rx, a);
        d = {rx, 8'h00};
        if (n > 1) begin
            byte_io(8'hff, 1'b1, rx, a);
            d[7:0] = rx;
        end
        stop();
    endtask
endmodule

// ---- verification/tb_top.sv ----
// testbench of the temperature sensor block
module tb_top import tsca_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 600;
    logic clock, nrst, clk_en, lclk, scl, host_low;
    logic [11:0] adc_code;
    logic sda_out, sda_oe, analog_on, osc_run, alert_out, alert_oe;
    int num_errors = 0;
    int checked = 0;
    // pull-up on the data wire
    wire logic sda = ~(host_low | sda_oe);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // link clock, unrelated in phase
    initial begin
        lclk = 1'b0;
        #7;
        forever #16 lclk = ~lclk;
    end

    tsca_core #(.PERIOD_CYCLES(1000), .CONV_CYCLES(CONV),
        .WAKE_CYCLES(20)) i_dut (.clock(clock), .nrst(nrst),
        .clk_en(clk_en), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .adc_code(adc_code), .analog_on(analog_on),
        .osc_run(osc_run), .alert_out(alert_out), .alert_oe(alert_oe));
    tsca_host i_host (.lclk(lclk), .sda(sda), .scl(scl),
        .sda_low(host_low));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic s, input logic e);
        chk({15'h0, s}, {15'h0, e});
    endtask
    task automatic rchk(input logic [7:0] p, input int n,
                        input logic [15:0] e);
        logic [15:0] v;
        i_host.rd(p, n, v);
        chk(v, e);
    endtask
    // waits end off the rising edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic note(input string s);
        $display("test %s finished", s);
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // tests need roughly 26000 cycles
    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        adc_code = 12'hc90;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        cyc(5);
        chk1(sda_oe, 1'b0);
        chk1(sda_out, 1'b0);
        chk1(alert_out, 1'b0);
        // reads halt the power-up conversion, so the old zero comes back
        rchk(PTR_TEMP, 2, 16'h0000);
        rchk(PTR_CFG, 2, 16'h0000);
        rchk(PTR_HYST, 2, 16'h4b00);
        rchk(PTR_OVER, 2, 16'h5000);
        rchk(8'h05, 2, 16'h0000);
        note("reset");
        cyc(300);
        chk1(analog_on, 1'b1);
        cyc(400);
        chk1(analog_on, 1'b0);
        chk1(osc_run, 1'b1);
        rchk(PTR_TEMP, 2, 16'hc900);
        note("conversion");
        i_host.wr(PTR_HYST, 16'h100f, 2);
        i_host.wr(PTR_OVER, 16'h1400, 2);
        i_host.wr(PTR_TEMP, 16'h1234, 2);
        rchk(PTR_HYST, 2, 16'h1000);
        rchk(PTR_TEMP, 2, 16'hc900);
        note("limits");
        @(posedge clock) adc_code <= 12'h200;
        i_host.wr(PTR_CFG, 16'h1800, 1);
        cyc(5000);
        chk1(alert_oe, 1'b0);
        cyc(800);
        chk1(alert_oe, 1'b1);
        note("fault queue");
        @(posedge clock) adc_code <= 12'h120;
        i_host.wr(PTR_CFG, 16'h0000, 1);
        cyc(700);
        chk1(alert_oe, 1'b1);
        @(posedge clock) adc_code <= 12'h0f0;
        cyc(1000);
        chk1(alert_oe, 1'b0);
        i_host.wr(PTR_CFG, 16'h0400, 1);
        cyc(5);
        chk1(alert_oe, 1'b1);
        note("comparator");
        i_host.wr(PTR_CFG, 16'h0100, 1);
        cyc(3);
        chk1(osc_run, 1'b0);
        @(posedge clock) adc_code <= 12'h050;
        cyc(2000);
        rchk(PTR_TEMP, 2, 16'h0f00);
        i_host.wr(PTR_CFG, 16'h0000, 1);
        cyc(10);
        chk1(osc_run, 1'b1);
        cyc(700);
        rchk(PTR_TEMP, 2, 16'h0500);
        note("shutdown");
        i_host.wr(PTR_CFG, 16'h2200, 1);
        cyc(3);
        chk1(osc_run, 1'b0);
        rchk(PTR_CFG, 2, 16'h2222);
        @(posedge clock) adc_code <= 12'h200;
        i_host.wr(PTR_SHOT, 16'h0000, 0);
        cyc(5);
        chk1(analog_on, 1'b1);
        // a one-shot result needs the full conversion time
        cyc(CONV + 100);
        chk1(osc_run, 1'b0);
        chk1(alert_oe, 1'b1);
        rchk(PTR_SHOT, 2, 16'h2000);
        chk1(alert_oe, 1'b0);
        rchk(PTR_TEMP, 2, 16'h2000);
        note("one-shot interrupt");
        i_host.wr(PTR_CFG, 16'h2000, 1);
        cyc(5);
        chk1(alert_oe, 1'b1);
        @(posedge clock) adc_code <= 12'h0f0;
        i_host.wr(PTR_SHOT, 16'h0000, 0);
        cyc(CONV + 100);
        chk1(alert_oe, 1'b0);
        rchk(PTR_TEMP, 1, 16'h0f00);
        note("one-shot comparator");
        stop_test();
    end
endmodule
